// ==== inc/mm_timer_pkg.sv ====
// Constants for the two-channel multi-mode timer: register map, fields, resets.
// Assumes a 4-bit register address and a 16-bit register data path.
`default_nettype none
package mm_timer_pkg;
  // ==========================================
  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CTRL_W = 8;
  // ==========================================
  // Register offsets
  localparam logic [3:0] ADDR_PER = 4'h0;
  localparam logic [3:0] ADDR_START = 4'h1;
  localparam logic [3:0] ADDR_FUNC = 4'h2;
  localparam logic [3:0] ADDR_OUTEN = 4'h3;
  localparam logic [3:0] ADDR_PDATA = 4'h4;
  localparam logic [3:0] ADDR_PMODE = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [1:0] CH_BASE_IDX = 2'h2;
  localparam logic [1:0] OFS_CTRL = 2'h0;
  localparam logic [1:0] OFS_COUNT = 2'h1;
  localparam logic [1:0] OFS_GRA = 2'h2;
  localparam logic [1:0] OFS_GRX = 2'h3;
  // ==========================================
  // Field positions
  localparam int PER_EN_BIT = 0;
  localparam int START_RUN_LSB = 0;
  localparam int START_CSEL_LSB = 2;
  localparam int FUNC_POS_PHASE_LEVEL_SEL_BIT = 0;
  localparam int FUNC_NEG_PHASE_LEVEL_SEL_BIT = 1;
  localparam int FUNC_CMD_LSB = 2;
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_EDGE_LSB = 3;
  localparam int CTRL_CAPEN_BIT = 5;
  localparam int CTRL_FILT_LSB = 6;
  localparam int STAT_MATCH_OFS = 0;
  localparam int STAT_CAP_OFS = 1;
  // ==========================================
  // Encodings
  localparam logic [1:0] CMD_TIMER = 2'h0;
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam int PRE_W = 5;
  // ==========================================
  // Reset values
  localparam logic [DATA_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [DATA_W-1:0] RST_GR = 16'hffff;
  localparam logic [CTRL_W-1:0] RST_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_ZERO = 16'h0000;
  // ==========================================
  // Channel run state
  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN = 2'b10
  } chan_state_t;
endpackage
`default_nettype wire

// ==== rtl/mm_timer.sv ====
// Two-channel 16-bit timer with match stop, input capture and pin muxing.
// Assumes all inputs synchronous to clk; register port answers reads next cycle.
// Contract
// - Timer clock enable off: control writes ignored, reads give reset values, ports exempt.
// - Stop-select 0: writing start 0 does nothing; only match with A clears start.
// - Software stop holds pin level; PWM combo modes output initial levels.
// - Match stop keeps match level; PWM combo modes output initial levels.
// - Counter write wins over counter becoming zero in the same cycle.
// - Capture loads general register two to three clocks after input edge.
// - Capture edge raises capture request even while channel stopped.
// - After reset all timer pins act as inputs.
// - Edge detection takes at least two clocks after the pin changes.
`default_nettype none
module mm_timer
  import mm_timer_pkg::*;
#(
  parameter int NCH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // Timer pins
  input wire logic [NCH-1:0] pinIn,
  output logic [NCH-1:0] pinOut,
  output logic [NCH-1:0] pinOe,
  input wire logic extClk,
  // Request levels
  output logic [NCH-1:0] irqReq
);
  if (NCH < 1 || NCH > 2) begin : gen_bad_nch
    $error("NCH must be 1 or 2");
  end

  // ==========================================
  // Shared registers
  logic timerClockEnable_ff, nxt_timerClockEnable;
  logic [NCH-1:0] stopSelect_ff, nxt_stopSelect;
  logic [3:0] funcCtrl_ff, nxt_funcCtrl;
  logic [NCH-1:0] outEn_ff, nxt_outEn;
  logic [NCH-1:0] portData_ff, nxt_portData;
  logic [NCH-1:0] portMode_ff, nxt_portMode;
  logic [2*NCH-1:0] status_ff, nxt_status;
  logic [PRE_W-1:0] pre_ff, nxt_pre;
  logic ext1_ff, ext2_ff, ext3_ff;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [NCH-1:0] runBits;
  logic [NCH-1:0][DATA_W-1:0] cntAll, graAll, grxAll;
  logic [NCH-1:0][CTRL_W-1:0] ctrlAll;
  logic [NCH-1:0] matchEv, capEv;
  logic wrStart;
  logic [1:0] chSel;
  logic chHit;
  logic [1:0] cmd;

  assign wrStart = wr && addr == ADDR_START && timerClockEnable_ff;
  assign chSel = addr[3:2] - CH_BASE_IDX;
  assign chHit = addr[3:2] >= CH_BASE_IDX && int'(chSel) < NCH;
  assign cmd = funcCtrl_ff[FUNC_CMD_LSB +: 2];

  always_comb begin
    nxt_timerClockEnable = timerClockEnable_ff;
    nxt_stopSelect = stopSelect_ff;
    nxt_funcCtrl = funcCtrl_ff;
    nxt_outEn = outEn_ff;
    nxt_portData = portData_ff;
    nxt_portMode = portMode_ff;
    nxt_pre = pre_ff + 1'b1;
    nxt_status = status_ff;
    if (wr) begin
      unique case (addr)
        ADDR_PER: nxt_timerClockEnable = wdata[PER_EN_BIT];
        ADDR_PDATA: nxt_portData = wdata[NCH-1:0];
        ADDR_PMODE: nxt_portMode = wdata[NCH-1:0];
        default: ;
      endcase
      if (timerClockEnable_ff) begin
        unique case (addr)
          ADDR_START: nxt_stopSelect = wdata[START_CSEL_LSB +: NCH];
          ADDR_FUNC: nxt_funcCtrl = wdata[3:0];
          ADDR_OUTEN: nxt_outEn = wdata[NCH-1:0];
          ADDR_STATUS: nxt_status = status_ff & ~wdata[2*NCH-1:0];
          default: ;
        endcase
      end
    end
    for (int c = 0; c < NCH; c++) begin
      nxt_status[2*c+STAT_MATCH_OFS] = nxt_status[2*c+STAT_MATCH_OFS] | matchEv[c];
      nxt_status[2*c+STAT_CAP_OFS] = nxt_status[2*c+STAT_CAP_OFS] | capEv[c];
    end
  end

  // Reads: gated registers show reset values while the timer clock is off
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd) begin
      nxt_rdata = RST_ZERO;
      unique case (addr)
        ADDR_PER: nxt_rdata[PER_EN_BIT] = timerClockEnable_ff;
        ADDR_PDATA: nxt_rdata[NCH-1:0] = portData_ff;
        ADDR_PMODE: nxt_rdata[NCH-1:0] = portMode_ff;
        default: ;
      endcase
      if (timerClockEnable_ff) begin
        unique case (addr)
          ADDR_START: begin
            nxt_rdata[START_RUN_LSB +: NCH] = runBits;
            nxt_rdata[START_CSEL_LSB +: NCH] = stopSelect_ff;
          end
          ADDR_FUNC: nxt_rdata[3:0] = funcCtrl_ff;
          ADDR_OUTEN: nxt_rdata[NCH-1:0] = outEn_ff;
          ADDR_STATUS: nxt_rdata[2*NCH-1:0] = status_ff;
          default: ;
        endcase
        if (chHit) begin
          unique case (addr[1:0])
            OFS_CTRL: nxt_rdata[CTRL_W-1:0] = ctrlAll[chSel];
            OFS_COUNT: nxt_rdata = cntAll[chSel];
            OFS_GRA: nxt_rdata = graAll[chSel];
            OFS_GRX: nxt_rdata = grxAll[chSel];
          endcase
        end
      end else if (chHit) begin
        unique case (addr[1:0])
          OFS_CTRL: nxt_rdata[CTRL_W-1:0] = RST_CTRL;
          OFS_COUNT: nxt_rdata = RST_COUNT;
          default: nxt_rdata = RST_GR;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timerClockEnable_ff <= 1'b0;
      stopSelect_ff <= '0;
      funcCtrl_ff <= '0;
      outEn_ff <= '0;
      portData_ff <= '0;
      portMode_ff <= '0;
      status_ff <= '0;
      pre_ff <= '0;
      ext1_ff <= 1'b0;
      ext2_ff <= 1'b0;
      ext3_ff <= 1'b0;
      rdata_ff <= '0;
    end else if (ce) begin
      timerClockEnable_ff <= nxt_timerClockEnable;
      stopSelect_ff <= nxt_stopSelect;
      funcCtrl_ff <= nxt_funcCtrl;
      outEn_ff <= nxt_outEn;
      portData_ff <= nxt_portData;
      portMode_ff <= nxt_portMode;
      status_ff <= nxt_status;
      pre_ff <= nxt_pre;
      ext1_ff <= extClk;
      ext2_ff <= ext1_ff;
      ext3_ff <= ext2_ff;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // ==========================================
  // Channels
  for (genvar g = 0; g < NCH; g++) begin : gen_ch
    chan_state_t state_ff, nxt_state;
    logic [DATA_W-1:0] cnt_ff, nxt_cnt, gra_ff, nxt_gra, grx_ff, nxt_grx;
    logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic s1_ff, s2_ff, s3_ff;
    logic outLvl_ff, nxt_outLvl, pinOut_ff, nxt_pinOut, pinOe_ff;
    logic tick, hit, edgeOk, wrCh, initLvl, comboMode;

    assign wrCh = wr && timerClockEnable_ff && chHit && int'(chSel) == g;
    assign comboMode = cmd != CMD_TIMER;
    assign initLvl = g == 0 ? funcCtrl_ff[FUNC_POS_PHASE_LEVEL_SEL_BIT] : funcCtrl_ff[FUNC_NEG_PHASE_LEVEL_SEL_BIT];

    always_comb begin
      unique case (ctrl_ff[CTRL_SRC_LSB +: 3])
        SRC_DIV1: tick = 1'b1;
        SRC_DIV2: tick = &pre_ff[0:0];
        SRC_DIV4: tick = &pre_ff[1:0];
        SRC_DIV8: tick = &pre_ff[2:0];
        SRC_DIV32: tick = &pre_ff;
        SRC_EXT: tick = ext2_ff && !ext3_ff;
        default: tick = 1'b0;
      endcase
      unique case (ctrl_ff[CTRL_EDGE_LSB +: 2])
        EDGE_RISE: edgeOk = s2_ff && !s3_ff;
        EDGE_FALL: edgeOk = !s2_ff && s3_ff;
        default: edgeOk = s2_ff != s3_ff;
      endcase
    end

    assign hit = state_ff == ST_RUN && tick && cnt_ff == gra_ff;
    assign matchEv[g] = hit;
    assign capEv[g] = ctrl_ff[CTRL_CAPEN_BIT] && edgeOk;

    always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_gra = gra_ff;
      nxt_grx = grx_ff;
      nxt_ctrl = ctrl_ff;
      nxt_outLvl = outLvl_ff;
      unique case (state_ff)
        ST_STOP: begin
          if (wrStart && wdata[START_RUN_LSB+g]) nxt_state = ST_RUN;
        end
        ST_RUN: begin
          if (hit && !stopSelect_ff[g]) nxt_state = ST_STOP;
          else if (wrStart && !wdata[START_RUN_LSB+g] && stopSelect_ff[g]) begin
            nxt_state = ST_STOP;
          end
        end
      endcase
      if (hit) begin
        nxt_cnt = RST_COUNT;
        nxt_outLvl = !outLvl_ff;
      end else if (state_ff == ST_RUN && tick) begin
        nxt_cnt = cnt_ff + 1'b1;
      end
      if (comboMode && nxt_state == ST_STOP) nxt_outLvl = initLvl;
      if (capEv[g]) nxt_grx = cnt_ff;
      if (wrCh) begin
        unique case (addr[1:0])
          OFS_CTRL: nxt_ctrl = wdata[CTRL_W-1:0];
          OFS_COUNT: nxt_cnt = wdata;
          OFS_GRA: nxt_gra = wdata;
          OFS_GRX: nxt_grx = wdata;
        endcase
      end
      nxt_pinOut = outEn_ff[g] ? nxt_outLvl : portData_ff[g];
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        state_ff <= ST_STOP;
        cnt_ff <= RST_COUNT;
        gra_ff <= RST_GR;
        grx_ff <= RST_GR;
        ctrl_ff <= RST_CTRL;
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
        outLvl_ff <= 1'b0;
        pinOut_ff <= 1'b0;
        pinOe_ff <= 1'b0;
      end else if (ce) begin
        state_ff <= nxt_state;
        cnt_ff <= nxt_cnt;
        gra_ff <= nxt_gra;
        grx_ff <= nxt_grx;
        ctrl_ff <= nxt_ctrl;
        s1_ff <= pinIn[g];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        outLvl_ff <= nxt_outLvl;
        pinOut_ff <= nxt_pinOut;
        pinOe_ff <= nxt_portMode[g];
      end
    end

    assign runBits[g] = state_ff == ST_RUN;
    assign cntAll[g] = cnt_ff;
    assign graAll[g] = gra_ff;
    assign grxAll[g] = grx_ff;
    assign ctrlAll[g] = ctrl_ff;
    assign pinOut[g] = pinOut_ff;
    assign pinOe[g] = pinOe_ff;
    assign irqReq[g] = status_ff[2*g+STAT_MATCH_OFS] | status_ff[2*g+STAT_CAP_OFS];
  end
endmodule // mm_timer
`default_nettype wire

// ==== test/mm_timer_sva.sv ====
// Port checker for the two-channel timer, bound into every timer instance.
// Assumes one clock domain and the register map of the timer package.
`default_nettype none
module mm_timer_sva
  import mm_timer_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [NCH-1:0] pinIn,
  input wire logic [NCH-1:0] pinOut,
  input wire logic [NCH-1:0] pinOe,
  input wire logic extClk,
  input wire logic [NCH-1:0] irqReq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic perEn_ff, nxt_perEn, capEn_ff, nxt_capEn;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ==========================================
  // Shadow of timer enable and channel 1 capture enable
  always_comb begin
    nxt_perEn = perEn_ff;
    nxt_capEn = capEn_ff;
    if (wr && ce && addr == ADDR_PER) nxt_perEn = wdata[PER_EN_BIT];
    if (wr && ce && perEn_ff && addr == 4'hc) begin
      nxt_capEn = wdata[CTRL_CAPEN_BIT] && wdata[CTRL_EDGE_LSB +: 2] != EDGE_FALL;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      perEn_ff <= 1'b0;
      capEn_ff <= 1'b0;
    end else begin
      perEn_ff <= nxt_perEn;
      capEn_ff <= nxt_capEn;
    end
  end
  // ==========================================
  // Port properties
  a_reset_quiet: assert property ($rose(resetn) |->
      pinOe == '0 && pinOut == '0 && irqReq == '0) else $error("pins not quiet after reset");
  a_off_start_zero: assert property (rd && ce && !perEn_ff && addr == ADDR_START |=>
      rdata == RST_ZERO) else $error("start read not zero while disabled");
  a_off_gra_ones: assert property (rd && ce && !perEn_ff && addr == 4'ha |=>
      rdata == RST_GR) else $error("compare read not reset value while disabled");
  a_unmapped_zero: assert property (rd && ce && addr == 4'h7 |=> rdata == RST_ZERO)
      else $error("unmapped read not zero");
  a_oe_follows: assert property (wr && ce && addr == ADDR_PMODE && wdata[0] |->
      ##2 pinOe[0]) else $error("pin drive not enabled");
  a_edge_not_early: assert property ($rose(pinIn[1]) && !irqReq[1] |=>
      !irqReq[1]) else $error("capture seen too early");
  a_capture_bound: assert property ($rose(pinIn[1]) && perEn_ff && capEn_ff && ce |->
      ##[2:4] irqReq[1]) else $error("capture request late");
  a_rdata_hold: assert property (!(rd && ce) |=> $stable(rdata))
      else $error("read data moved without read");
  a_freeze_hold: assert property (!ce |=> $stable(rdata) && $stable(pinOut) && $stable(irqReq))
      else $error("outputs moved while frozen");
  cover property (rd && addr == 4'hf);
  cover property ($rose(irqReq[0]));
  cover property (!ce);
  cover property ($rose(extClk));
endmodule // mm_timer_sva
bind mm_timer mm_timer_sva #(.NCH(NCH)) i_sva (.clk(clk), .resetn(resetn), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pinIn(pinIn),
  .pinOut(pinOut), .pinOe(pinOe), .extClk(extClk), .irqReq(irqReq));
`default_nettype wire

// ==== test/mm_timer_far.sv ====
// Far side of the timer pins: pulse sources, external count clock, pad loopback.
// Assumes the bench calls its tasks; a driven pad reads back the block's own level.
`default_nettype none
module mm_timer_far #(
  parameter int NCH = 2
) (
  input wire logic clk,
  input wire logic [NCH-1:0] pinOut,
  input wire logic [NCH-1:0] pinOe,
  output logic [NCH-1:0] pinIn,
  output logic extClk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [NCH-1:0] srcLvl = '0;
  // Block driver wins, else external source
  assign pinIn = (pinOe & pinOut) | (~pinOe & srcLvl);
  initial extClk = 1'b0;
  task automatic pulse(input int ch, input int w);
    @(posedge clk);
    srcLvl[ch] <= 1'b1;
    repeat (w) @(posedge clk);
    srcLvl[ch] <= 1'b0;
  endtask
  task automatic clocks(input int n);
    repeat (n) begin
      @(posedge clk);
      extClk <= 1'b1;
      repeat (3) @(posedge clk);
      extClk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // mm_timer_far
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the two-channel timer over its strobe register port.
// Assumes the timer package, the far-side model and the bound port checker.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mm_timer_pkg::*;
  logic clk, resetn, ce, wrStb, rdStb, extClk;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, got;
  logic [1:0] pinIn, pinOut, pinOe, irqReq;
  int nErrors = 0;
  int nTests = 0;
  mm_timer i_dut (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wrStb), .rd(rdStb), .rdata(rdata), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .extClk(extClk), .irqReq(irqReq));
  mm_timer_far i_far (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn),
    .extClk(extClk));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    nTests++;
    if (g !== e) begin
      nErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic regWr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wrStb <= 1'b1;
    rdStb <= 1'b0;
    addr <= a;
    wdata <= d;
  endtask
  task automatic regGet(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rdStb <= 1'b1;
    wrStb <= 1'b0;
    addr <= a;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic regRd(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    regGet(a, d);
    chk(d, e);
  endtask
  task automatic idle(input int n);
    @(posedge clk);
    wrStb <= 1'b0;
    rdStb <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finalReport;
    $display("errors=%0d comparisons=%0d", nErrors, nTests);
    if (nErrors == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    nErrors++;
    finalReport;
  end
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    wrStb = 1'b0;
    rdStb = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1 chk({14'h0, pinOe}, 16'h0000);
    regWr(ADDR_START, 16'h0001);
    regRd(ADDR_START, 16'h0000);
    regRd(4'ha, RST_GR);
    regWr(ADDR_PDATA, 16'h0003);
    regRd(ADDR_PDATA, 16'h0003);
    regRd(4'h7, RST_ZERO);
    idle(2);
    chk({14'h0, pinOut}, 16'h0003);
    regWr(ADDR_PDATA, 16'h0000);
    regWr(ADDR_PER, 16'h0001);
    regWr(4'ha, 16'h0005);
    regWr(ADDR_OUTEN, 16'h0001);
    regWr(ADDR_PMODE, 16'h0001);
    regWr(ADDR_START, 16'h0001);
    regWr(ADDR_START, 16'h0000);
    regRd(ADDR_START, 16'h0001);
    idle(12);
    regRd(ADDR_START, 16'h0000);
    regRd(ADDR_STATUS, 16'h0001);
    idle(4);
    chk({14'h0, pinOut}, 16'h0001);
    chk({14'h0, pinOe}, 16'h0001);
    regWr(ADDR_STATUS, 16'h000f);
    regWr(ADDR_START, 16'h0001);
    regWr(ADDR_START, 16'h0004);
    regRd(ADDR_START, 16'h0005);
    regWr(ADDR_START, 16'h0004);
    regRd(ADDR_START, 16'h0004);
    idle(8);
    chk({14'h0, pinOut}, 16'h0001);
    regWr(ADDR_STATUS, 16'h000f);
    regWr(ADDR_START, 16'h0005);
    regWr(4'ha, 16'h0002);
    regWr(4'h9, 16'h0002);
    regWr(4'h9, 16'h0007);
    regGet(4'h9, got);
    chk(got, 16'h0007);
    regWr(ADDR_START, 16'h0004);
    regWr(ADDR_FUNC, 16'h0000);
    regWr(ADDR_FUNC, 16'h0007);
    idle(3);
    chk({14'h0, pinOut}, 16'h0001);
    regWr(ADDR_FUNC, 16'h0004);
    idle(3);
    chk({14'h0, pinOut}, 16'h0000);
    regWr(ADDR_FUNC, 16'h0000);
    regWr(4'hc, 16'h0005);
    regWr(ADDR_STATUS, 16'h000f);
    regWr(ADDR_START, 16'h000a);
    idle(1);
    i_far.clocks(4);
    idle(4);
    regWr(ADDR_START, 16'h0008);
    regRd(4'hd, 16'h0004);
    regWr(4'hc, 16'h0020);
    regWr(4'hd, 16'h0123);
    regWr(ADDR_STATUS, 16'h000f);
    idle(1);
    i_far.pulse(1, 3);
    idle(3);
    regRd(4'hf, 16'h0123);
    regRd(ADDR_STATUS, 16'h0008);
    ce <= 1'b0;
    regWr(ADDR_PDATA, 16'h0003);
    idle(3);
    ce <= 1'b1;
    regRd(ADDR_PDATA, 16'h0000);
    resetn <= 1'b0;
    idle(2);
    chk({14'h0, pinOe}, 16'h0000);
    resetn <= 1'b1;
    regRd(4'ha, RST_GR);
    finalReport;
  end
endmodule // tb
`default_nettype wire
